// [verilog/rtccfg_defines.svh]
`ifndef RTCCFG_DEFINES_SVH
`define RTCCFG_DEFINES_SVH

// register bus
`define RTCCFG_ADDR_W 4
`define RTCCFG_DATA_W 16
`define RTCCFG_ADDR_CFG 4'h0
`define RTCCFG_ADDR_WIN 4'h2
`define RTCCFG_ADDR_STAT 4'h4
`define RTCCFG_ADDR_MASK 4'h6

// configuration word fields
`define RTCCFG_BIT_EN 15
`define RTCCFG_BIT_UNUSED 14
`define RTCCFG_BIT_UNLOCK 13
`define RTCCFG_BIT_RIPPLE 12
`define RTCCFG_BIT_HALF 11
`define RTCCFG_BIT_OE 10
`define RTCCFG_PTR_HI 9
`define RTCCFG_PTR_LO 8
`define RTCCFG_CAL_HI 7
`define RTCCFG_CAL_LO 0
`define RTCCFG_CFG_RESET 16'h0000

// window pointer codes
`define RTCCFG_PTR_MIN_SEC_VALUE 2'h0
`define RTCCFG_PTR_ONE 2'h1

// interrupt status layout
`define RTCCFG_IRQ_W 3
`define RTCCFG_IRQ_HALF 0
`define RTCCFG_IRQ_SEC 1
`define RTCCFG_IRQ_LOCKED 2
`define RTCCFG_IRQ_RESET 3'h0

// drift trim
`define RTCCFG_CAL_W 8
`define RTCCFG_PULSES_PER_COUNT 4

`endif

// [verilog/rtccfg_pkg.sv]
package rtccfg_pkg;

    typedef enum logic [1:0]
    {
        RTCCFG_TRIM_IDLE = 2'b01,
        RTCCFG_TRIM_RUN = 2'b10
    } rtccfg_trim_state_t;

    typedef logic [1:0] rtccfg_ptr_t;

endpackage

// [verilog/rtccfg_trim_if.sv]
`timescale 1ns/1ps
`include "rtccfg_defines.svh"

interface rtccfg_trim_if;
    logic [`RTCCFG_CAL_W-1:0] cal;
    logic enable;
    logic minuteTick;
    logic srcTick;
    logic trimmedTick;

    modport ctrl
    (
        output cal,
        output enable,
        output minuteTick,
        output srcTick,
        input trimmedTick
    );

    modport trim
    (
        input cal,
        input enable,
        input minuteTick,
        input srcTick,
        output trimmedTick
    );
endinterface

// [verilog/rtccfg_trim.sv]
`timescale 1ns/1ps
`include "rtccfg_defines.svh"

module rtccfg_trim
    import rtccfg_pkg::*;
#(
    parameter int CAL_W = `RTCCFG_CAL_W,
    parameter int PULSES_PER_COUNT = `RTCCFG_PULSES_PER_COUNT
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    rtccfg_trim_if.trim trimIf
);
    localparam int CNT_W = $clog2(PULSES_PER_COUNT * (2 ** (CAL_W - 1)) + 1);
    localparam logic [CNT_W-1:0] PPC = CNT_W'(PULSES_PER_COUNT);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    generate
        if (CAL_W < 2 || PULSES_PER_COUNT < 1)
        begin : g_bad
            $error("rtccfg_trim: unsupported trim width or pulse count");
        end
    endgenerate

    rtccfg_trim_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic neg_q, neg_d;
    logic extra_q, extra_d;
    logic tick_q, tick_d;

    wire logic calNeg = trimIf.cal[CAL_W-1];
    wire logic [CAL_W:0] calExt = {1'b0, trimIf.cal};
    wire logic [CAL_W:0] calAbs = calNeg ? (~calExt + 1'b1) : calExt;
    wire logic [CNT_W-1:0] loadCnt = CNT_W'(calAbs) * PPC;

    // signed trim turned into pulses per minute
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        neg_d = neg_q;
        extra_d = 1'b0;
        tick_d = trimIf.srcTick;
        case (state_q)
            RTCCFG_TRIM_IDLE:
            begin
                if (trimIf.minuteTick && (calAbs != '0))
                begin
                    cnt_d = loadCnt;
                    neg_d = calNeg;
                    state_d = RTCCFG_TRIM_RUN;
                end
            end
            RTCCFG_TRIM_RUN:
            begin
                tick_d = trimIf.srcTick | extra_q;
                if (trimIf.srcTick)
                begin
                    // swallow for a slow trim, echo a tick one cycle on
                    tick_d = ~neg_q;
                    extra_d = ~neg_q;
                    cnt_d = cnt_q - CNT_ONE;
                    if (cnt_q == CNT_ONE)
                    begin
                        state_d = RTCCFG_TRIM_IDLE;
                    end
                end
            end
            default:
            begin
                state_d = RTCCFG_TRIM_IDLE;
            end
        endcase
        if (!trimIf.enable)
        begin
            state_d = RTCCFG_TRIM_IDLE;
            tick_d = 1'b0;
            extra_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= RTCCFG_TRIM_IDLE;
            cnt_q <= '0;
            neg_q <= 1'b0;
            extra_q <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            neg_q <= neg_d;
            extra_q <= extra_d;
            tick_q <= tick_d | extra_q;
        end
    end

    assign trimIf.trimmedTick = tick_q;
endmodule

// [verilog/rtccfg_ctrl.sv]
// Summary of operation
// - The enable bit 15 runs the calendar module when 1 and stops it when 0.
// - A write changes the enable bit only while the unlock bit is already 1.
// - Window writes reach the time registers only while unlock bit 13 is 1.
// - Bit 12 is set while a rollover ripple may disturb a read, else clear.
// - Bit 11 reads 1 in the second half of each second and 0 in the first.
// - Writing the seconds half of the minutes/seconds pair clears bit 11.
// - The clock output is driven only while output enable bit 10 is 1.
// - Pointer bits 9-8 pick min/sec, weekday/hour, month/day or year.
// - Each window read or accepted window write steps the pointer down by one, stopping at 00.
// - Only power-on reset clears the configuration word to zero.
// - Bit 14 always reads 0 and ignores writes.
// - The signed trim adds or drops four clock pulses per count a minute.
// - The unlock bit can be set only in the cycle right after the key.
`timescale 1ns/1ps
`include "rtccfg_defines.svh"

module rtccfg_ctrl
    import rtccfg_pkg::*;
#(
    parameter int ADDR_W = `RTCCFG_ADDR_W,
    parameter int DATA_W = `RTCCFG_DATA_W
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sysReset,
    input wire logic [ADDR_W-1:0] busAddr,
    input wire logic [DATA_W-1:0] busWrData,
    input wire logic busWrStrobe,
    input wire logic busRdStrobe,
    output logic [DATA_W-1:0] busRdData,
    input wire logic unlockWindow,
    input wire logic rippleActive,
    input wire logic halfSecTick,
    input wire logic secondTick,
    input wire logic minuteTick,
    input wire logic srcTick,
    input wire logic clkOutSource,
    input wire logic [DATA_W-1:0] valueRdData,
    output logic calendarEnable,
    output logic [1:0] valueWindowSel,
    output logic valueWrStrobe,
    output logic [1:0] valueWrSel,
    output logic [DATA_W-1:0] valueWrData,
    output logic trimmedTick,
    output logic clkOut,
    output logic clkOutEnable,
    output logic irq
);
    generate
        if (ADDR_W < 3 || DATA_W != `RTCCFG_DATA_W)
        begin : g_bad
            $error("rtccfg_ctrl: bus width not supported");
        end
    endgenerate

    localparam logic [ADDR_W-1:0] A_CFG = ADDR_W'(`RTCCFG_ADDR_CFG);
    localparam logic [ADDR_W-1:0] A_WIN = ADDR_W'(`RTCCFG_ADDR_WIN);
    localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(`RTCCFG_ADDR_STAT);
    localparam logic [ADDR_W-1:0] A_MASK = ADDR_W'(`RTCCFG_ADDR_MASK);

    // configuration word state
    logic enable_q, enable_d;
    logic unlock_q, unlock_d;
    logic ripple_q;
    logic half_q, half_d;
    logic oe_q, oe_d;
    rtccfg_ptr_t ptr_q, ptr_d;
    logic [`RTCCFG_CAL_W-1:0] cal_q, cal_d;

    // interrupt state
    logic [`RTCCFG_IRQ_W-1:0] stat_q, stat_d;
    logic [`RTCCFG_IRQ_W-1:0] mask_q, mask_d;

    // outputs held in flip-flops
    logic [DATA_W-1:0] rdData_q, rdData_d;
    logic wrStrobe_q;
    rtccfg_ptr_t wrSel_q;
    logic [DATA_W-1:0] wrData_q;
    logic clkOut_q;

    // address decode
    wire logic selCfg = (busAddr == A_CFG);
    wire logic selWin = (busAddr == A_WIN);
    wire logic selStat = (busAddr == A_STAT);
    wire logic selMask = (busAddr == A_MASK);
    wire logic wrCfg = busWrStrobe && selCfg;
    wire logic wrWin = busWrStrobe && selWin;
    wire logic rdWin = busRdStrobe && selWin;
    wire logic wrStat = busWrStrobe && selStat;
    wire logic wrMask = busWrStrobe && selMask;

    // window write gate and its side effects
    wire logic winWrAccepted = wrWin && unlock_q;
    wire logic winWrRefused = wrWin && !unlock_q;
    wire logic secondsWrite = winWrAccepted
        && (ptr_q == `RTCCFG_PTR_MIN_SEC_VALUE);
    // a refused write leaves the pointer alone so a retry hits the same pair
    wire logic winStep = rdWin || winWrAccepted;

    // configuration word as software sees it
    wire logic [DATA_W-1:0] cfgWord =
    {
        enable_q,
        1'b0,
        unlock_q,
        ripple_q,
        half_q,
        oe_q,
        ptr_q,
        cal_q
    };

    wire logic [DATA_W-1:0] statWord = DATA_W'(stat_q);
    wire logic [DATA_W-1:0] maskWord = DATA_W'(mask_q);

    // read selection
    wire logic [DATA_W-1:0] rdSel =
        selCfg ? cfgWord :
        selWin ? valueRdData :
        selStat ? statWord :
        selMask ? maskWord :
        '0;

    // events latched into the status register
    wire logic [`RTCCFG_IRQ_W-1:0] events =
    {
        winWrRefused,
        secondTick,
        halfSecTick
    };

    // configuration word next state
    always_comb
    begin
        enable_d = enable_q;
        unlock_d = unlock_q;
        oe_d = oe_q;
        ptr_d = ptr_q;
        cal_d = cal_q;
        if (wrCfg)
        begin
            if (unlock_q)
            begin
                enable_d = busWrData[`RTCCFG_BIT_EN];
            end
            // setting needs the key window, clearing is always allowed
            if (!busWrData[`RTCCFG_BIT_UNLOCK])
            begin
                unlock_d = 1'b0;
            end
            else if (unlockWindow)
            begin
                unlock_d = 1'b1;
            end
            oe_d = busWrData[`RTCCFG_BIT_OE];
            ptr_d = busWrData[`RTCCFG_PTR_HI:`RTCCFG_PTR_LO];
            cal_d = busWrData[`RTCCFG_CAL_HI:`RTCCFG_CAL_LO];
        end
        else if (winStep && (ptr_q != `RTCCFG_PTR_MIN_SEC_VALUE))
        begin
            ptr_d = ptr_q - `RTCCFG_PTR_ONE;
        end
    end

    // half-second flag: set at mid-second, cleared at the second boundary
    always_comb
    begin
        half_d = half_q;
        if (secondTick || secondsWrite)
        begin
            half_d = 1'b0;
        end
        if (halfSecTick)
        begin
            half_d = 1'b1;
        end
    end

    // sticky status, write one to clear, a new event wins
    always_comb
    begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (wrStat)
        begin
            stat_d = stat_q & ~busWrData[`RTCCFG_IRQ_W-1:0];
        end
        stat_d = stat_d | events;
        if (wrMask)
        begin
            mask_d = busWrData[`RTCCFG_IRQ_W-1:0];
        end
    end

    // read data only in the cycle after the strobe
    always_comb
    begin
        rdData_d = '0;
        if (busRdStrobe)
        begin
            rdData_d = rdSel;
        end
    end

    // configuration word: power-on reset only, system reset ignored
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_q <= 1'(`RTCCFG_CFG_RESET >> `RTCCFG_BIT_EN);
            unlock_q <= 1'b0;
            oe_q <= 1'b0;
            ptr_q <= `RTCCFG_PTR_MIN_SEC_VALUE;
            cal_q <= '0;
        end
        else
        begin
            enable_q <= enable_d;
            unlock_q <= unlock_d;
            oe_q <= oe_d;
            ptr_q <= ptr_d;
            cal_q <= cal_d;
        end
    end

    // hardware status bits taken into this clock's registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ripple_q <= 1'b0;
            half_q <= 1'b0;
        end
        else
        begin
            ripple_q <= rippleActive;
            half_q <= half_d;
        end
    end

    // interrupt registers also follow the system reset
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat_q <= `RTCCFG_IRQ_RESET;
            mask_q <= `RTCCFG_IRQ_RESET;
        end
        else if (sysReset)
        begin
            stat_q <= `RTCCFG_IRQ_RESET;
            mask_q <= `RTCCFG_IRQ_RESET;
        end
        else
        begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    // bus read data and window write forwarding
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdData_q <= '0;
            wrStrobe_q <= 1'b0;
            wrSel_q <= `RTCCFG_PTR_MIN_SEC_VALUE;
            wrData_q <= '0;
        end
        else
        begin
            rdData_q <= rdData_d;
            wrStrobe_q <= winWrAccepted;
            if (winWrAccepted)
            begin
                wrSel_q <= ptr_q;
                wrData_q <= busWrData;
            end
        end
    end

    // clock output gated by the output enable bit
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clkOut_q <= 1'b0;
        end
        else
        begin
            clkOut_q <= oe_q && clkOutSource;
        end
    end

    // drift trim engine
    rtccfg_trim_if trimIf();

    assign trimIf.cal = cal_q;
    assign trimIf.enable = enable_q;
    assign trimIf.minuteTick = minuteTick;
    assign trimIf.srcTick = srcTick;

    rtccfg_trim #(
        .CAL_W(`RTCCFG_CAL_W),
        .PULSES_PER_COUNT(`RTCCFG_PULSES_PER_COUNT)
    ) u_trim (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .trimIf(trimIf)
    );

    assign busRdData = rdData_q;
    assign calendarEnable = enable_q;
    assign valueWindowSel = ptr_q;
    assign valueWrStrobe = wrStrobe_q;
    assign valueWrSel = wrSel_q;
    assign valueWrData = wrData_q;
    assign trimmedTick = trimIf.trimmedTick;
    assign clkOut = clkOut_q;
    assign clkOutEnable = oe_q;
    // software checks ripple by reading twice; nothing here enforces it
    assign irq = |(stat_q & mask_q);
endmodule

// [sim/rtccfg_ctrl_monitor.sv]
`timescale 1ns/1ps
`include "rtccfg_defines.svh"

module rtccfg_ctrl_monitor
#(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 16
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sysReset,
    input wire logic [ADDR_W-1:0] busAddr,
    input wire logic busWrStrobe,
    input wire logic busRdStrobe,
    input wire logic [DATA_W-1:0] busRdData,
    input wire logic rippleActive,
    input wire logic srcTick,
    input wire logic clkOutSource,
    input wire logic calendarEnable,
    input wire logic [1:0] valueWindowSel,
    input wire logic valueWrStrobe,
    input wire logic [1:0] valueWrSel,
    input wire logic trimmedTick,
    input wire logic clkOut,
    input wire logic clkOutEnable
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_winRd;
        busRdStrobe && busAddr == `RTCCFG_ADDR_WIN;
    endsequence
    sequence s_cfgRd;
        busRdStrobe && busAddr == `RTCCFG_ADDR_CFG;
    endsequence

    property p_enSrc;
        $changed(calendarEnable) |->
            $past(busWrStrobe && busAddr == `RTCCFG_ADDR_CFG);
    endproperty
    a_enSrc: assert property (p_enSrc)
        else $error("enable moved without a config write");

    property p_ptrStep;
        s_winRd ##0 (valueWindowSel != 2'h0) |=>
            valueWindowSel == $past(valueWindowSel) - 2'h1;
    endproperty
    a_ptrStep: assert property (p_ptrStep)
        else $error("pointer did not step down");

    property p_ptrHold;
        s_winRd ##0 (valueWindowSel == 2'h0) |=> valueWindowSel == 2'h0;
    endproperty
    a_ptrHold: assert property (p_ptrHold)
        else $error("pointer left zero");

    property p_wrSel;
        valueWrStrobe |-> $past(busWrStrobe)
            && valueWrSel == $past(valueWindowSel);
    endproperty
    a_wrSel: assert property (p_wrSel)
        else $error("window write pair wrong");

    // ripple flag lags its source by one cycle, read adds one
    property p_ripple;
        s_cfgRd |=> busRdData[12] == $past(rippleActive, 2);
    endproperty
    a_ripple: assert property (p_ripple)
        else $error("ripple flag wrong");

    // only the config word; window data may use that bit freely
    property p_bit14;
        s_cfgRd |=> !busRdData[`RTCCFG_BIT_UNUSED];
    endproperty
    a_bit14: assert property (p_bit14)
        else $error("bit 14 read as one");

    property p_clkOut;
        1'b1 |-> clkOut == ($past(clkOutSource) && $past(clkOutEnable));
    endproperty
    a_clkOut: assert property (p_clkOut)
        else $error("clock output not gated by enable");

    property p_trim;
        trimmedTick |-> $past(srcTick) || $past(srcTick, 2);
    endproperty
    a_trim: assert property (p_trim)
        else $error("trimmed tick without source tick");

    property p_offNoTick;
        !calendarEnable [*2] |=> !trimmedTick;
    endproperty
    a_offNoTick: assert property (p_offNoTick)
        else $error("tick while module disabled");

    property p_sysRst;
        sysReset && !busWrStrobe && !busRdStrobe |=>
            $stable(calendarEnable)
            && $stable(valueWindowSel) && $stable(clkOutEnable);
    endproperty
    a_sysRst: assert property (p_sysRst)
        else $error("config changed by system reset");
endmodule

bind rtccfg_ctrl rtccfg_ctrl_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    mon_u
(
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sysReset(sysReset),
    .busAddr(busAddr),
    .busWrStrobe(busWrStrobe),
    .busRdStrobe(busRdStrobe),
    .busRdData(busRdData),
    .rippleActive(rippleActive),
    .srcTick(srcTick),
    .clkOutSource(clkOutSource),
    .calendarEnable(calendarEnable),
    .valueWindowSel(valueWindowSel),
    .valueWrStrobe(valueWrStrobe),
    .valueWrSel(valueWrSel),
    .trimmedTick(trimmedTick),
    .clkOut(clkOut),
    .clkOutEnable(clkOutEnable)
);

// [sim/rtccfg_ctrl_tb_top.sv]
`timescale 1ns/1ps
`include "rtccfg_defines.svh"

module rtccfg_ctrl_tb_top
    import rtccfg_pkg::*;
;
    typedef struct {logic u; logic [15:0] d; logic [15:0] e;} rtccfg_row_t;
    localparam logic [3:0] CFG = `RTCCFG_ADDR_CFG;
    localparam logic [3:0] WIN = `RTCCFG_ADDR_WIN;
    localparam logic [3:0] STAT = `RTCCFG_ADDR_STAT;
    localparam logic [3:0] MASK = `RTCCFG_ADDR_MASK;
    logic ref_clk = 0, rst_n = 0, sysReset = 0, busWrStrobe = 0;
    logic busRdStrobe = 0, unlockWindow = 0, rippleActive = 0;
    logic halfSecTick = 0, secondTick = 0, minuteTick = 0, srcTick = 0;
    logic clkOutSource = 0, calendarEnable, valueWrStrobe, trimmedTick;
    logic clkOut, clkOutEnable, irq;
    logic [3:0] busAddr = '0;
    logic [15:0] busWrData = '0, busRdData, valueRdData, valueWrData;
    rtccfg_ptr_t valueWindowSel, valueWrSel;
    int err_count = 0, checked = 0, tickCount = 0;
    // enable writes need the unlock already set, so order matters
    rtccfg_row_t rows [6] = '{'{1'b0, 16'hffff, 16'h07ff},
        '{1'b1, 16'ha000, 16'h2000}, '{1'b1, 16'ha400, 16'ha400},
        '{1'b0, 16'h8000, 16'h8000}, '{1'b0, 16'h0081, 16'h8081},
        '{1'b1, 16'h2300, 16'ha300}};

    assign valueRdData = {8'h5a, 6'h00, valueWindowSel};

    rtccfg_ctrl dut_u
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .sysReset(sysReset),
        .busAddr(busAddr), .busWrData(busWrData),
        .busWrStrobe(busWrStrobe), .busRdStrobe(busRdStrobe),
        .busRdData(busRdData), .unlockWindow(unlockWindow),
        .rippleActive(rippleActive), .halfSecTick(halfSecTick),
        .secondTick(secondTick), .minuteTick(minuteTick),
        .srcTick(srcTick), .clkOutSource(clkOutSource),
        .valueRdData(valueRdData), .calendarEnable(calendarEnable),
        .valueWindowSel(valueWindowSel), .valueWrStrobe(valueWrStrobe),
        .valueWrSel(valueWrSel), .valueWrData(valueWrData),
        .trimmedTick(trimmedTick), .clkOut(clkOut),
        .clkOutEnable(clkOutEnable), .irq(irq)
    );

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        clkOutSource <= ~clkOutSource;
        if (trimmedTick === 1'b1)
            tickCount <= tickCount + 1;
    end

    task automatic finish_test;
        $display("compares %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] s, e);
        checked++;
        if (s !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d,
        input logic u);
        @(posedge ref_clk);
        busAddr <= a;
        busWrData <= d;
        busWrStrobe <= 1'b1;
        unlockWindow <= u;
        @(posedge ref_clk);
        busWrStrobe <= 1'b0;
        unlockWindow <= 1'b0;
        #1;
    endtask

    task automatic rdChk(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        busAddr <= a;
        busRdStrobe <= 1'b1;
        @(posedge ref_clk);
        busRdStrobe <= 1'b0;
        #1;
        chk("read", busRdData, e);
    endtask

    // 0 half, 1 second, 2 minute, 3 source tick
    task automatic tick(input int k);
        @(posedge ref_clk);
        halfSecTick <= (k == 0);
        secondTick <= (k == 1);
        minuteTick <= (k == 2);
        srcTick <= (k == 3);
        @(posedge ref_clk);
        {halfSecTick, secondTick, minuteTick, srcTick} <= 4'h0;
        #1;
    endtask

    // source ticks kept five cycles apart, the engine needs two
    task automatic trimRun(input logic [15:0] c, input int n, e);
        int t0;
        wr(CFG, c, 1'b1);
        tick(2);
        t0 = tickCount;
        repeat (n)
        begin
            tick(3);
            repeat (3) @(posedge ref_clk);
        end
        chk("trim ticks", 16'(tickCount - t0), 16'(e));
    endtask

    initial
    begin
        #200000;
        err_count++;
        finish_test;
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            wr(CFG, rows[i].d, rows[i].u);
            rdChk(CFG, rows[i].e);
            chk("enable", calendarEnable, rows[i].e[15]);
            chk("pointer", valueWindowSel, rows[i].e[9:8]);
            chk("oe", clkOutEnable, rows[i].e[10]);
        end
        for (int i = 0; i < 5; i++)
        begin
            wr(WIN, 16'h1200 + 16'(i), 1'b0);
            chk("wr strobe", valueWrStrobe, 1'b1);
            chk("wr sel", valueWrSel,
                (i < 3) ? 2'(3 - i) : 2'h0);
            chk("wr data", valueWrData, 16'h1200 + 16'(i));
        end
        wr(CFG, 16'ha200, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            rdChk(WIN,
                {8'h5a, 6'h00, (i < 2) ? 2'(2 - i) : 2'h0});
        end
        wr(MASK, 16'h0007, 1'b0);
        wr(CFG, 16'h8100, 1'b0);
        wr(WIN, 16'hbeef, 1'b0);
        chk("locked wr", valueWrStrobe, 1'b0);
        chk("locked ptr", valueWindowSel, 2'h1);
        chk("irq set", irq, 1'b1);
        rdChk(STAT, 16'h0004);
        wr(STAT, 16'h0004, 1'b0);
        chk("irq clr", irq, 1'b0);
        tick(0);
        rdChk(CFG, 16'h8900);
        tick(1);
        rdChk(CFG, 16'h8100);
        tick(0);
        wr(CFG, 16'ha000, 1'b1);
        rdChk(CFG, 16'ha800);
        wr(WIN, 16'h0000, 1'b0);
        rdChk(CFG, 16'ha000);
        rdChk(STAT, 16'h0003);
        wr(MASK, 16'h0000, 1'b0);
        chk("irq masked", irq, 1'b0);
        wr(STAT, 16'h0003, 1'b0);
        @(posedge ref_clk);
        rippleActive <= 1'b1;
        rdChk(CFG, 16'hb000);
        // under ripple two window reads must agree before use
        rdChk(WIN, 16'h5a00);
        rdChk(WIN, 16'h5a00);
        @(posedge ref_clk);
        rippleActive <= 1'b0;
        rdChk(CFG, 16'ha000);
        wr(4'h8, 16'hffff, 1'b1);
        rdChk(4'h8, 16'h0000);
        rdChk(CFG, 16'ha000);
        trimRun(16'ha47f, 510, 1018);
        trimRun(16'ha480, 514, 2);
        trimRun(16'ha400, 5, 5);
        trimRun(16'h2401, 3, 0);
        wr(MASK, 16'h0007, 1'b0);
        tick(0);
        chk("irq half", irq, 1'b1);
        @(posedge ref_clk);
        sysReset <= 1'b1;
        @(posedge ref_clk);
        sysReset <= 1'b0;
        #1;
        chk("irq sys", irq, 1'b0);
        chk("clk out", clkOut, !clkOutSource);
        rdChk(CFG, 16'h2c01);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdChk(CFG, 16'h0000);
        chk("en por", calendarEnable, 1'b0);
        chk("clk off", clkOut, 1'b0);
        finish_test;
    end
endmodule
